// >>> core/dps_slave_services.sv
// slave service engine: cyclic images, config check, acyclic services, alarms
//
// Notes on behaviour
// - cyclic exchange is always started before any waiting acyclic request.
// - slot zero reaches coupler blocks, higher slots reach module blocks.
// - no data block is larger than 244 bytes.
// - the request length bounds the transfer, allowing partial block access.
// - a new alarm waits until the open alarm has been acknowledged.
// - status messages go out at once and expect no acknowledgment.
// - class-1 channel services only from the master that configured us.
// - class-2 read, write, transport need an open connection, else refused.
// - several class-2 connections may be open together, up to table size.
// - data transport writes the block then returns data in one exchange.
// - read returns the block, write stores the supplied bytes into it.
// - an abort closes the connection and frees its entry.
// - each module's cyclic bytes sit at a fixed image position.
// - configuration must match the real modules before cyclic exchange.
// - cyclic images never exceed 244 input and 244 output bytes.
// - only requests for our own address, lying in 2 to 125, are served.
`timescale 1ns/100ps
`default_nettype none
module dps_slave_services #(
  parameter int IN_BYTES = 244,
  parameter int OUT_BYTES = 244,
  parameter int NUM_MOD = 4,
  parameter int COUPLER_IDX = 2,
  parameter int MOD_IDX = 1,
  parameter int NUM_CONN = 4
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [6:0] stationAddr,
  input wire logic reqValid,
  input wire logic [3:0] reqService,
  input wire logic [1:0] reqChannel,
  input wire logic [6:0] reqMaster,
  input wire logic [6:0] reqDest,
  input wire logic [7:0] reqSlot,
  input wire logic [7:0] reqIndex,
  input wire logic [7:0] reqLength,
  output logic reqReady_q,
  output logic cycReady_q,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  output logic rxReady_q,
  output logic txValid_q,
  output logic [7:0] txData_q,
  output logic txLast_q,
  output logic respValid_q,
  output logic [3:0] respCode_q,
  input wire logic [IN_BYTES*8-1:0] inImage,
  output logic [OUT_BYTES*8-1:0] outImage_q,
  input wire logic [NUM_MOD*8-1:0] actualCfg,
  output logic dataExch_q,
  input wire logic alarmReq,
  input wire logic [7:0] alarmCode,
  output logic alarmReady_q,
  output logic alarmSend_q,
  output logic [7:0] alarmCodeOut_q,
  output logic alarmOpen_q,
  input wire logic statusReq,
  input wire logic [7:0] statusCode,
  output logic statusSend_q,
  output logic [7:0] statusCodeOut_q
);
  localparam int NUM_BLOCKS = COUPLER_IDX + NUM_MOD * MOD_IDX;
  localparam int BLK_W = $clog2(NUM_BLOCKS);
  localparam logic [7:0] BLOCK_MAX = 8'(dps_pkg::MAX_BLOCK_BYTES);
  // last byte index of each image and of the configuration, one below its byte count
  localparam logic [7:0] OUT_LAST = 8'(OUT_BYTES - 1);
  localparam logic [7:0] IN_LAST = 8'(IN_BYTES - 1);
  localparam logic [7:0] CFG_LAST = 8'(NUM_MOD - 1);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  dps_pkg::dps_state_e state_q, stateD;
  logic [7:0] cnt_q, cntD, len_q, lenD;
  logic [3:0] rsp_q, rspD, svc_q, svcD;
  logic [BLK_W-1:0] blk_q, blkD;
  logic [6:0] master_q, masterD, owner_q;
  logic cfgBad_q, cfgBadD;
  logic cycPend_q, acyPend_q;
  logic [6:0] cycMaster_q, acyMaster_q;
  logic [3:0] acySvc_q;
  logic [1:0] acyChan_q;
  logic [7:0] acySlot_q, acyIdx_q, acyLen_q;
  logic alarmWait_q;
  logic [7:0] alarmWaitCode_q;
  logic [7:0] rdByte;
  logic connHit, connFull;

  // address of a block inside the shared store
  function automatic logic [BLK_W-1:0] blockOf(logic [7:0] slot, logic [7:0] idx);
    return BLK_W'((slot == dps_pkg::COUPLER_SLOT) ? int'(idx)
      : COUPLER_IDX + (int'(slot) - 1) * MOD_IDX + int'(idx));
  endfunction

  function automatic logic blockExists(logic [7:0] slot, logic [7:0] idx);
    return (slot == dps_pkg::COUPLER_SLOT) ? (int'(idx) < COUPLER_IDX)
      : (int'(slot) <= NUM_MOD) && (int'(idx) < MOD_IDX);
  endfunction

  function automatic logic isRx(dps_pkg::dps_state_e st);
    return st == dps_pkg::ST_CYC_RX || st == dps_pkg::ST_CFG_RX || st == dps_pkg::ST_ACY_RX;
  endfunction

  // acyclic decode: returns next state and response code
  function automatic logic [6:0] dispatch(logic [3:0] svc, logic [1:0] chan, logic ownerOk,
      logic hit, logic full, logic addrOk, logic lenZero);
    logic [2:0] st;
    logic [3:0] rs;
    st = dps_pkg::ST_RESP;
    rs = dps_pkg::RSP_OK;
    case (svc)
      dps_pkg::SVC_CONFIG: begin
        if (chan == dps_pkg::CH_MS0) st = dps_pkg::ST_CFG_RX;
        else rs = dps_pkg::RSP_NEG_SVC;
      end
      dps_pkg::SVC_READ, dps_pkg::SVC_WRITE, dps_pkg::SVC_DATA_TRANSPORT: begin
        if (chan == dps_pkg::CH_MS1 && svc != dps_pkg::SVC_DATA_TRANSPORT) begin
          if (!ownerOk) rs = dps_pkg::RSP_NEG_OWNER;
        end else if (chan == dps_pkg::CH_MS2) begin
          if (!hit) rs = dps_pkg::RSP_NEG_CONN;
        end else begin
          rs = dps_pkg::RSP_NEG_SVC;
        end
        if (rs == dps_pkg::RSP_OK && !addrOk) rs = dps_pkg::RSP_NEG_ADDR;
        if (rs == dps_pkg::RSP_OK && !lenZero) begin
          st = (svc == dps_pkg::SVC_READ) ? dps_pkg::ST_ACY_TX : dps_pkg::ST_ACY_RX;
        end
      end
      dps_pkg::SVC_ALARM_ACK: begin
        if (chan != dps_pkg::CH_MS1) rs = dps_pkg::RSP_NEG_SVC;
        else if (!ownerOk) rs = dps_pkg::RSP_NEG_OWNER;
      end
      dps_pkg::SVC_INITIATE: begin
        if (chan != dps_pkg::CH_MS2) rs = dps_pkg::RSP_NEG_SVC;
        else if (full && !hit) rs = dps_pkg::RSP_NEG_RES;
      end
      dps_pkg::SVC_ABORT: begin
        if (chan != dps_pkg::CH_MS2) rs = dps_pkg::RSP_NEG_SVC;
      end
      default: rs = dps_pkg::RSP_NEG_SVC;
    endcase
    return {st, rs};
  endfunction

  // own address only, and only a legal one
  wire addrInRange = stationAddr >= dps_pkg::STATION_MIN && stationAddr <= dps_pkg::STATION_MAX;
  wire forMe = reqValid && addrInRange && (reqDest == stationAddr);
  wire isCycReq = reqService == dps_pkg::SVC_CYCLIC;
  wire cycTake = forMe && isCycReq && cycReady_q;
  wire acyTake = forMe && !isCycReq && reqReady_q;
  wire inIdle = state_q == dps_pkg::ST_IDLE;
  wire startCyc = inIdle && cycPend_q;
  wire startAcy = inIdle && acyPend_q && !cycPend_q;
  wire cycPendD = cycTake || (cycPend_q && !startCyc);
  wire acyPendD = acyTake || (acyPend_q && !startAcy);
  wire rxTake = rxValid && rxReady_q;

  wire ownerOk = acyChan_q == dps_pkg::CH_MS1 && dataExch_q && acyMaster_q == owner_q;
  wire addrOk = blockExists(acySlot_q, acyIdx_q) && acyLen_q <= BLOCK_MAX;
  wire [6:0] decision = dispatch(acySvc_q, acyChan_q, ownerOk, connHit, connFull, addrOk,
    acyLen_q == 8'h00);
  wire [3:0] goRsp = decision[3:0];
  wire dps_pkg::dps_state_e goState = dps_pkg::dps_state_e'(decision[6:4]);
  // cyclic refused until the configuration matched
  wire cycOk = dataExch_q && cycMaster_q == owner_q;
  wire goAcyOk = startAcy && goRsp == dps_pkg::RSP_OK;
  wire ackNow = goAcyOk && acySvc_q == dps_pkg::SVC_ALARM_ACK;
  wire connOpen = goAcyOk && acySvc_q == dps_pkg::SVC_INITIATE;
  wire connClose = goAcyOk && acySvc_q == dps_pkg::SVC_ABORT;
  wire lastLen = cnt_q == 8'(len_q - 8'h01);
  wire [7:0] cfgByte = actualCfg[cnt_q*8 +: 8];
  wire [7:0] inByte = inImage[cnt_q*8 +: 8];
  wire cfgDone = state_q == dps_pkg::ST_CFG_RX && rxTake && cnt_q == CFG_LAST;
  wire storeWr = state_q == dps_pkg::ST_ACY_RX && rxTake;

  dps_block_store #(.NUM_BLOCKS(NUM_BLOCKS), .BLK_W(BLK_W)) uStore (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .wrEn(storeWr),
    .wrBlock(blk_q),
    .wrOffset(cnt_q),
    .wrData(rxData),
    .rdBlock(blk_q),
    .rdOffset(cnt_q),
    .rdData(rdByte)
  );

  dps_conn_table #(.NUM_CONN(NUM_CONN)) uConn (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .openReq(connOpen),
    .closeReq(connClose),
    .reqMaster(acyMaster_q),
    .hit(connHit),
    .full(connFull)
  );

  // transaction sequencing
  always_comb begin
    stateD = state_q;
    cntD = cnt_q;
    rspD = rsp_q;
    blkD = blk_q;
    lenD = len_q;
    svcD = svc_q;
    masterD = master_q;
    cfgBadD = cfgBad_q;
    case (state_q)
      dps_pkg::ST_IDLE: begin
        cntD = 8'h00;
        cfgBadD = 1'b0;
        if (startCyc) begin
          stateD = cycOk ? dps_pkg::ST_CYC_RX : dps_pkg::ST_RESP;
          rspD = cycOk ? dps_pkg::RSP_OK : dps_pkg::RSP_NEG_CFG;
          svcD = dps_pkg::SVC_CYCLIC;
          masterD = cycMaster_q;
        end else if (startAcy) begin
          stateD = goState;
          rspD = goRsp;
          blkD = blockOf(acySlot_q, acyIdx_q);
          lenD = acyLen_q;
          svcD = acySvc_q;
          masterD = acyMaster_q;
        end
      end
      dps_pkg::ST_CYC_RX: begin
        if (rxTake) begin
          cntD = (cnt_q == OUT_LAST) ? 8'h00 : cnt_q + 8'h01;
          if (cnt_q == OUT_LAST) stateD = dps_pkg::ST_CYC_TX;
        end
      end
      dps_pkg::ST_CYC_TX: begin
        cntD = cnt_q + 8'h01;
        if (cnt_q == IN_LAST) stateD = dps_pkg::ST_RESP;
      end
      dps_pkg::ST_CFG_RX: begin
        if (rxTake) begin
          cntD = cnt_q + 8'h01;
          cfgBadD = cfgBad_q || rxData != cfgByte;
          if (cnt_q == CFG_LAST) begin
            stateD = dps_pkg::ST_RESP;
            rspD = cfgBadD ? dps_pkg::RSP_NEG_CFG : dps_pkg::RSP_OK;
          end
        end
      end
      dps_pkg::ST_ACY_RX: begin
        if (rxTake) begin
          cntD = lastLen ? 8'h00 : cnt_q + 8'h01;
          // transport turns round to a read-back
          if (lastLen) begin
            stateD = (svc_q == dps_pkg::SVC_DATA_TRANSPORT) ? dps_pkg::ST_ACY_TX : dps_pkg::ST_RESP;
          end
        end
      end
      dps_pkg::ST_ACY_TX: begin
        cntD = cnt_q + 8'h01;
        if (lastLen) stateD = dps_pkg::ST_RESP;
      end
      dps_pkg::ST_RESP: stateD = dps_pkg::ST_IDLE;
      default: stateD = dps_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= dps_pkg::ST_IDLE;
      cnt_q <= 8'h00;
      len_q <= 8'h00;
      rsp_q <= dps_pkg::RSP_OK;
      svc_q <= dps_pkg::SVC_CYCLIC;
      blk_q <= '0;
      master_q <= 7'h00;
      cfgBad_q <= 1'b0;
    end else begin
      state_q <= stateD;
      cnt_q <= cntD;
      len_q <= lenD;
      rsp_q <= rspD;
      svc_q <= svcD;
      blk_q <= blkD;
      master_q <= masterD;
      cfgBad_q <= cfgBadD;
    end
  end

  // request holding slots; ready flags mirror the slot about to be free
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cycPend_q <= 1'b0;
      acyPend_q <= 1'b0;
      cycReady_q <= 1'b0;
      reqReady_q <= 1'b0;
      cycMaster_q <= 7'h00;
      {acyMaster_q, acySvc_q, acyChan_q} <= '0;
      {acySlot_q, acyIdx_q, acyLen_q} <= '0;
    end else begin
      cycPend_q <= cycPendD;
      acyPend_q <= acyPendD;
      cycReady_q <= !cycPendD;
      reqReady_q <= !acyPendD;
      if (cycTake) cycMaster_q <= reqMaster;
      if (acyTake) begin
        {acyMaster_q, acySvc_q, acyChan_q} <= {reqMaster, reqService, reqChannel};
        {acySlot_q, acyIdx_q, acyLen_q} <= {reqSlot, reqIndex, reqLength};
      end
    end
  end

  // byte streams and response; tx has no back-pressure, master must sink it
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rxReady_q <= 1'b0;
      txValid_q <= 1'b0;
      txData_q <= 8'h00;
      txLast_q <= 1'b0;
      respValid_q <= 1'b0;
      respCode_q <= dps_pkg::RSP_OK;
    end else begin
      rxReady_q <= isRx(stateD);
      txValid_q <= state_q == dps_pkg::ST_CYC_TX || state_q == dps_pkg::ST_ACY_TX;
      txData_q <= (state_q == dps_pkg::ST_CYC_TX) ? inByte : rdByte;
      txLast_q <= (state_q == dps_pkg::ST_CYC_TX && cnt_q == IN_LAST) ||
        (state_q == dps_pkg::ST_ACY_TX && lastLen);
      respValid_q <= state_q == dps_pkg::ST_RESP;
      respCode_q <= rsp_q;
    end
  end

  // output image and ownership; a failed check drops data exchange
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      outImage_q <= '0;
      dataExch_q <= 1'b0;
      owner_q <= 7'h00;
    end else begin
      // byte n always lands at image position n
      if (state_q == dps_pkg::ST_CYC_RX && rxTake) outImage_q[cnt_q*8 +: 8] <= rxData;
      // enter exchange only on a full match
      if (cfgDone) begin
        dataExch_q <= !cfgBadD;
        owner_q <= master_q;
      end
    end
  end

  // alarm held until acknowledge, one waiting alarm at most
  wire alarmFree = !alarmOpen_q || ackNow;
  wire sendWait = alarmWait_q && alarmFree;
  wire sendNew = alarmReq && alarmReady_q && alarmFree;
  wire setWait = alarmReq && alarmReady_q && !alarmFree;
  wire alarmWaitD = setWait || (alarmWait_q && !sendWait);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      alarmOpen_q <= 1'b0;
      alarmWait_q <= 1'b0;
      alarmWaitCode_q <= 8'h00;
      alarmReady_q <= 1'b0;
      alarmSend_q <= 1'b0;
      alarmCodeOut_q <= 8'h00;
    end else begin
      alarmOpen_q <= sendWait || sendNew || (alarmOpen_q && !ackNow);
      alarmWait_q <= alarmWaitD;
      alarmReady_q <= !alarmWaitD;
      alarmSend_q <= sendWait || sendNew;
      if (setWait) alarmWaitCode_q <= alarmCode;
      if (sendWait) alarmCodeOut_q <= alarmWaitCode_q;
      else if (sendNew) alarmCodeOut_q <= alarmCode;
    end
  end

  // status goes out next cycle, nothing awaited
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      statusSend_q <= 1'b0;
      statusCodeOut_q <= 8'h00;
    end else begin
      statusSend_q <= statusReq;
      if (statusReq) statusCodeOut_q <= statusCode;
    end
  end

  sequence seqNeg(logic [3:0] code);
    state_q == dps_pkg::ST_RESP && rsp_q == code ##1 respValid_q && respCode_q == code;
  endsequence

  chk_cyclic_first: assert property (
    inIdle && cycPend_q && acyPend_q |=> svc_q == dps_pkg::SVC_CYCLIC && acyPend_q)
    else $error("acyclic started ahead of cyclic");
  chk_slot_zero: assert property (
    startAcy && acySlot_q == dps_pkg::COUPLER_SLOT && goRsp == dps_pkg::RSP_OK &&
    goState != dps_pkg::ST_RESP |=> int'(blk_q) < COUPLER_IDX)
    else $error("slot zero left coupler blocks");
  chk_len_bound: assert property (
    state_q == dps_pkg::ST_ACY_TX |-> cnt_q < len_q && len_q <= BLOCK_MAX)
    else $error("read ran past length");
  chk_alarm_hold: assert property (
    alarmSend_q |-> $past(alarmFree))
    else $error("alarm sent while one open");
  chk_status_nowait: assert property (
    statusReq |=> statusSend_q && statusCodeOut_q == $past(statusCode))
    else $error("status not sent next cycle");
  chk_owner_only: assert property (
    startAcy && acyChan_q == dps_pkg::CH_MS1 && !ownerOk && acySvc_q == dps_pkg::SVC_READ
    |=> seqNeg(dps_pkg::RSP_NEG_OWNER))
    else $error("foreign class-1 read accepted");
  chk_conn_needed: assert property (
    startAcy && acyChan_q == dps_pkg::CH_MS2 && !connHit && acySvc_q == dps_pkg::SVC_WRITE
    |=> seqNeg(dps_pkg::RSP_NEG_CONN))
    else $error("write on closed connection accepted");
  chk_bad_block: assert property (
    startAcy && ownerOk && !addrOk && acySvc_q == dps_pkg::SVC_READ
    |=> seqNeg(dps_pkg::RSP_NEG_ADDR))
    else $error("bad block not refused");
  chk_init_full: assert property (
    startAcy && acyChan_q == dps_pkg::CH_MS2 && acySvc_q == dps_pkg::SVC_INITIATE &&
    connFull && !connHit |=> seqNeg(dps_pkg::RSP_NEG_RES))
    else $error("initiate accepted with table full");
  chk_cfg_gate: assert property (
    startCyc && !dataExch_q |=> seqNeg(dps_pkg::RSP_NEG_CFG))
    else $error("cyclic without configuration");
  chk_own_addr: assert property (
    $rose(acyPend_q) |-> $past(forMe))
    else $error("request for other station taken");
endmodule // dps_slave_services
`default_nettype wire

// >>> core/dps_pkg.sv
// shared constants and encodings for the field-bus slave service logic
`default_nettype none
package dps_pkg;
  // largest data block and largest cyclic image, in bytes
  localparam int MAX_BLOCK_BYTES = 244;
  localparam int MAX_IMAGE_BYTES = 244;
  // legal own station address range
  localparam logic [6:0] STATION_MIN = 7'h02;
  localparam logic [6:0] STATION_MAX = 7'h7d;
  localparam logic [7:0] COUPLER_SLOT = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  typedef enum logic [3:0] {
    SVC_CYCLIC = 4'h0,
    SVC_CONFIG = 4'h1,
    SVC_READ = 4'h2,
    SVC_WRITE = 4'h3,
    SVC_ALARM_ACK = 4'h4,
    SVC_INITIATE = 4'h5,
    SVC_ABORT = 4'h6,
    SVC_DATA_TRANSPORT = 4'h7
  } dps_svc_e;

  typedef enum logic [1:0] {
    CH_MS0 = 2'h0,
    CH_MS1 = 2'h1,
    CH_MS2 = 2'h2
  } dps_chan_e;

  typedef enum logic [3:0] {
    RSP_OK = 4'h0,
    RSP_NEG_ADDR = 4'h1,
    RSP_NEG_CONN = 4'h2,
    RSP_NEG_RES = 4'h3,
    RSP_NEG_OWNER = 4'h4,
    RSP_NEG_CFG = 4'h5,
    RSP_NEG_SVC = 4'h6
  } dps_rsp_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CYC_RX = 3'h1,
    ST_CYC_TX = 3'h2,
    ST_CFG_RX = 3'h3,
    ST_ACY_RX = 3'h4,
    ST_ACY_TX = 3'h5,
    ST_RESP = 3'h6
  } dps_state_e;
endpackage
`default_nettype wire

// >>> core/dps_block_store.sv
// flip-flop storage for all slot/index data blocks
`timescale 1ns/100ps
`default_nettype none
module dps_block_store #(
  parameter int NUM_BLOCKS = 6,
  parameter int BLK_W = 3
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic wrEn,
  input wire logic [BLK_W-1:0] wrBlock,
  input wire logic [7:0] wrOffset,
  input wire logic [7:0] wrData,
  input wire logic [BLK_W-1:0] rdBlock,
  input wire logic [7:0] rdOffset,
  output logic [7:0] rdData
);
  localparam int DEPTH = NUM_BLOCKS * dps_pkg::MAX_BLOCK_BYTES;

  logic [7:0] mem_q [DEPTH];

  // every block spans the full maximum size, so offsets never alias
  function automatic int flatIndex(logic [BLK_W-1:0] blk, logic [7:0] off);
    return int'(blk) * dps_pkg::MAX_BLOCK_BYTES + int'(off);
  endfunction

  assign rdData = mem_q[flatIndex(rdBlock, rdOffset)];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= dps_pkg::BYTE_RESET;
      end
    end else if (wrEn) begin
      mem_q[flatIndex(wrBlock, wrOffset)] <= wrData;
    end
  end
endmodule // dps_block_store
`default_nettype wire

// >>> core/dps_conn_table.sv
// table of open class-2 connections, one entry per master
`timescale 1ns/100ps
`default_nettype none
module dps_conn_table #(
  parameter int NUM_CONN = 4
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic openReq,
  input wire logic closeReq,
  input wire logic [6:0] reqMaster,
  output logic hit,
  output logic full
);
  logic [NUM_CONN-1:0] used_q;
  logic [NUM_CONN-1:0] matchVec;
  logic [NUM_CONN-1:0] freeSel;

  // lowest free entry as a one-hot vector
  function automatic logic [NUM_CONN-1:0] lowestFree(logic [NUM_CONN-1:0] used);
    logic [NUM_CONN-1:0] sel;
    logic found;
    sel = '0;
    found = 1'b0;
    for (int i = 0; i < NUM_CONN; i++) begin
      if (!used[i] && !found) begin
        sel[i] = 1'b1;
        found = 1'b1;
      end
    end
    return sel;
  endfunction

  assign freeSel = lowestFree(used_q);
  assign hit = |matchVec;
  assign full = &used_q;

  for (genvar g = 0; g < NUM_CONN; g++) begin : gEntry
    logic [6:0] owner_q;
    assign matchVec[g] = used_q[g] && (owner_q == reqMaster);
    // re-initiate by an open master reuses its entry
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        used_q[g] <= 1'b0;
        owner_q <= 7'h00;
      end else if (openReq && !hit && freeSel[g]) begin
        used_q[g] <= 1'b1;
        owner_q <= reqMaster;
      end else if (closeReq && matchVec[g]) begin
        used_q[g] <= 1'b0;
      end
    end
  end
endmodule // dps_conn_table
`default_nettype wire

// >>> test/dps_master_model.sv
// far-side master model: feeds bytes to the slave, collects its stream
`timescale 1ns/100ps
`default_nettype none
module dps_master_model (
  input wire logic sys_clk,
  input wire logic rxReady_q,
  input wire logic txValid_q,
  input wire logic [7:0] txData_q,
  input wire logic slow,
  output logic rxValid,
  output logic [7:0] rxData
);
  logic [7:0] feed[$];
  logic [7:0] got[$];
  logic tog = 1'b0;
  initial begin
    rxValid = 1'b0;
    rxData = 8'h00;
  end
  // only the queued length is sent
  always @(posedge sys_clk) begin
    #1;
    tog = ~tog;
    if (txValid_q === 1'b1) got.push_back(txData_q);
    if (rxReady_q === 1'b1 && feed.size() > 0 && !(slow && tog)) begin
      rxValid = 1'b1;
      rxData = feed.pop_front();
    end else begin
      rxValid = 1'b0;
      rxData = ~rxData; // idle line inverts each cycle, never the same value twice running
    end
  end
endmodule // dps_master_model
`default_nettype wire

// >>> test/dps_slave_services_tb.sv
// self-checking bench for the slave service engine
`timescale 1ns/100ps
`default_nettype none
module dps_slave_services_tb;
  localparam logic [3:0] RD = dps_pkg::SVC_READ;
  localparam logic [3:0] OK = dps_pkg::RSP_OK;
  localparam logic [1:0] C1 = dps_pkg::CH_MS1;
  localparam logic [1:0] C2 = dps_pkg::CH_MS2;
  localparam logic [3:0] NONE = 4'hf; // request must stay unanswered
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic reqValid = 1'b0, alarmReq = 1'b0, statusReq = 1'b0, slow = 1'b0;
  logic [3:0] reqService = 4'h0, respCode_q;
  logic [1:0] reqChannel = 2'h0;
  logic [6:0] reqMaster = 7'h00, reqDest = 7'h05, stationAddr = 7'h05;
  logic [7:0] reqSlot = 8'h00, reqIndex = 8'h00, reqLength = 8'h00;
  logic [7:0] alarmCode = 8'h00, statusCode = 8'h00, txData_q, rxData, alarmCodeOut_q, statusCodeOut_q;
  logic [31:0] inImage = 32'h0, actualCfg = 32'h0, outImage_q, e;
  logic reqReady_q, cycReady_q, rxReady_q, txValid_q, txLast_q, respValid_q, dataExch_q;
  logic alarmReady_q, alarmSend_q, alarmOpen_q, statusSend_q, rxValid;
  int mismatches = 0, samples_checked = 0, nAlarm = 0, k, lastAt = 0;
  int mem[int];
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (alarmSend_q === 1'b1) nAlarm++;
  // byte count at the moment the last-byte flag stood
  always @(posedge sys_clk) if (txLast_q === 1'b1) lastAt = mm.got.size();
  dps_slave_services #(.IN_BYTES(4), .OUT_BYTES(4), .NUM_CONN(2)) dut (.sys_clk, .resetn,
    .stationAddr, .reqValid, .reqService, .reqChannel, .reqMaster, .reqDest, .reqSlot, .reqIndex,
    .reqLength, .reqReady_q, .cycReady_q, .rxValid, .rxData, .rxReady_q, .txValid_q, .txData_q,
    .txLast_q, .respValid_q, .respCode_q, .inImage, .outImage_q, .actualCfg, .dataExch_q, .alarmReq,
    .alarmCode, .alarmReady_q, .alarmSend_q, .alarmCodeOut_q, .alarmOpen_q, .statusReq, .statusCode,
    .statusSend_q, .statusCodeOut_q);
  dps_master_model mm (.sys_clk, .rxReady_q, .txValid_q, .txData_q, .slow, .rxValid, .rxData);
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  // one strobe once the slot is free; an edge always passes first
  task automatic pulse(input logic [3:0] sv, input logic [1:0] ch, input logic [6:0] m,
    input logic [7:0] s, input logic [7:0] i, input logic [7:0] l);
    do tick(); while ((sv == dps_pkg::SVC_CYCLIC ? cycReady_q : reqReady_q) !== 1'b1);
    {reqService, reqChannel, reqMaster, reqSlot, reqIndex, reqLength} = {sv, ch, m, s, i, l};
    reqValid = 1'b1;
    tick();
    reqValid = 1'b0;
  endtask
  // next answer; a stale code cannot pass, silence is checked too
  task automatic waitResp(input logic [3:0] rsp);
    int n = 0;
    do begin
      tick();
      n++;
    end while (respValid_q !== 1'b1 && n < 400);
    chk("answered", respValid_q, rsp != NONE);
    if (rsp != NONE) chk("respCode", respCode_q, rsp);
  endtask
  task automatic req(input logic [3:0] sv, input logic [1:0] ch, input logic [6:0] m,
    input logic [7:0] s, input logic [7:0] i, input logic [7:0] l, input logic [3:0] rsp);
    mm.got.delete();
    lastAt = 0;
    pulse(sv, ch, m, s, i, l);
    waitResp(rsp);
  endtask
  // store random bytes in the reference and queue them for the slave
  task automatic wr(input logic [1:0] ch, input logic [6:0] m, input int s, input int i, input int l,
    input logic [3:0] sv);
    for (k = 0; k < l; k++) begin
      mem[s*65536+i*256+k] = $urandom % 256;
      mm.feed.push_back(8'(mem[s*65536+i*256+k]));
    end
    req(sv, ch, m, 8'(s), 8'(i), 8'(l), OK);
  endtask
  task automatic rd(input int l, input int s, input int i);
    chk("txCount", mm.got.size(), l);
    chk("txLast", lastAt, l);
    for (k = 0; k < l && k < mm.got.size(); k++) chk("txByte", mm.got[k], mem[s*65536+i*256+k]);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
  // main sequence: config, cyclic, class-1, class-2, alarm, status
  initial begin
    void'($urandom(31));
    repeat (20) @(posedge sys_clk);
    #1 resetn = 1'b1;
    tick();
    tick();
    actualCfg = $urandom;
    inImage = $urandom;
    e = $urandom;
    req(dps_pkg::SVC_CYCLIC, 2'h0, 1, 0, 0, 0, dps_pkg::RSP_NEG_CFG);
    // identifiers sent with bit 0 of byte 2 flipped, so the check must fail
    for (k = 0; k < 4; k++) mm.feed.push_back(actualCfg[8*k+:8] ^ 8'(k == 2));
    req(dps_pkg::SVC_CONFIG, 2'h0, 1, 0, 0, 0, dps_pkg::RSP_NEG_CFG);
    for (k = 0; k < 4; k++) mm.feed.push_back(actualCfg[8*k+:8]);
    req(dps_pkg::SVC_CONFIG, 2'h0, 1, 0, 0, 0, OK);
    chk("dataExch", dataExch_q, 1);
    slow = 1'b1;
    for (k = 0; k < 4; k++) mm.feed.push_back(e[8*k+:8]);
    req(dps_pkg::SVC_CYCLIC, 2'h0, 1, 0, 0, 0, OK);
    chk("outImage", outImage_q, e);
    chk("inImage", {mm.got[3], mm.got[2], mm.got[1], mm.got[0]}, inImage);
    chk("cycLast", lastAt, 4);
    slow = 1'b0;
    wr(C1, 1, 1, 0, 3, dps_pkg::SVC_WRITE);
    req(RD, C1, 1, 1, 0, 2, OK);
    rd(2, 1, 0);
    wr(C1, 1, 0, 1, 2, dps_pkg::SVC_WRITE);
    req(RD, C1, 1, 0, 1, 2, OK);
    rd(2, 0, 1);
    req(RD, C1, 9, 1, 0, 2, dps_pkg::RSP_NEG_OWNER);
    req(RD, C1, 1, 5, 0, 1, dps_pkg::RSP_NEG_ADDR);
    req(RD, C1, 1, 1, 0, 8'hf5, dps_pkg::RSP_NEG_ADDR);
    req(RD, C1, 1, 2, 0, 8'hf4, OK);
    chk("blkLen", mm.got.size(), 244);
    req(dps_pkg::SVC_DATA_TRANSPORT, C1, 1, 1, 0, 1, dps_pkg::RSP_NEG_SVC);
    // write stalls for data while an ack and a cyclic request queue up
    e = $urandom;
    pulse(dps_pkg::SVC_WRITE, C1, 1, 1, 0, 1);
    pulse(dps_pkg::SVC_ALARM_ACK, C1, 1, 0, 0, 0);
    pulse(dps_pkg::SVC_CYCLIC, 2'h0, 1, 0, 0, 0);
    mem[65536] = $urandom % 256;
    mm.feed.push_back(8'(mem[65536]));
    for (k = 0; k < 4; k++) mm.feed.push_back(e[8*k+:8]);
    waitResp(OK);
    waitResp(OK);
    chk("ackWaits", reqReady_q, 0);
    waitResp(OK);
    chk("cycFirst", outImage_q, e);
    // class-2 traffic only while no cyclic work waits
    req(RD, C2, 20, 1, 0, 1, dps_pkg::RSP_NEG_CONN);
    req(dps_pkg::SVC_INITIATE, C2, 20, 0, 0, 0, OK);
    req(dps_pkg::SVC_INITIATE, C2, 21, 0, 0, 0, OK);
    req(dps_pkg::SVC_INITIATE, C2, 22, 0, 0, 0, dps_pkg::RSP_NEG_RES);
    wr(C2, 21, 1, 0, 2, dps_pkg::SVC_DATA_TRANSPORT);
    rd(2, 1, 0);
    req(dps_pkg::SVC_ABORT, C2, 21, 0, 0, 0, OK);
    req(dps_pkg::SVC_WRITE, C2, 21, 1, 0, 1, dps_pkg::RSP_NEG_CONN);
    reqDest = 7'h06;
    req(RD, C1, 1, 1, 0, 0, NONE);
    stationAddr = 7'h7e;
    reqDest = 7'h7e;
    req(RD, C1, 1, 1, 0, 0, NONE);
    stationAddr = 7'h05;
    reqDest = 7'h05;
    req(dps_pkg::SVC_INITIATE, C2, 22, 0, 0, 0, OK);
    alarmCode = 8'h3c;
    alarmReq = 1'b1;
    tick();
    alarmReq = 1'b0;
    alarmCode = 8'h5a;
    repeat (3) tick();
    chk("alarmCode", alarmCodeOut_q, 8'h3c);
    alarmReq = 1'b1;
    tick();
    alarmReq = 1'b0;
    repeat (5) tick();
    chk("alarmHeld", nAlarm, 1);
    chk("alarmFlags", {alarmOpen_q, alarmReady_q}, 2'b10);
    req(dps_pkg::SVC_ALARM_ACK, C1, 1, 0, 0, 0, OK);
    chk("alarmNext", {nAlarm[23:0], alarmCodeOut_q}, 32'h25a);
    chk("alarmFlags", {alarmOpen_q, alarmReady_q}, 2'b11);
    statusCode = 8'h77;
    statusReq = 1'b1;
    tick();
    statusReq = 1'b0;
    chk("status", {statusSend_q, statusCodeOut_q}, 9'h177);
    tick();
    chk("statusEnd", statusSend_q, 0);
    tally_and_finish();
  end
endmodule // dps_slave_services_tb
`default_nettype wire
